/* File: hdl/dtra_fifo.sv */
// capture storage: shift-out word fifo with a tail load for profiling
`timescale 1ns/1ps
module dtra_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic push,
   input wire logic [WIDTH-1:0] pushData,
   input wire logic shift,
   input wire logic [WIDTH-1:0] shiftData,
   output logic [WIDTH-1:0] head,
   output logic full
);
   localparam int CW = $clog2(DEPTH + 1);

   // whole state of the fifo
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // word 0 is the head
      logic [CW-1:0] cnt;               // words held: a push below full adds one, a shift above zero takes one off
   } dtra_fifo_state_t;

   dtra_fifo_state_t st_r;
   dtra_fifo_state_t st_nxt;

   // next state: push appends, shift moves every word toward the head
   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt.cnt = '0;
      end else if (push && (st_r.cnt != CW'(DEPTH))) begin
         st_nxt.mem[st_r.cnt] = pushData;
         st_nxt.cnt = st_r.cnt + CW'(1);
      end else if (shift) begin
         // the tail always takes the new word, so a read never starves
         for (int i = 0; i < DEPTH - 1; i++) begin
            st_nxt.mem[i] = st_r.mem[i+1];
         end
         st_nxt.mem[DEPTH-1] = shiftData;
         if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - CW'(1);
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign head = st_r.mem[0];
   assign full = (st_r.cnt == CW'(DEPTH));
endmodule : dtra_fifo

/* File: hdl/dtra_pkg.sv */
// shared constants and carrier types of the debug trace register block
package dtra_pkg;
   // register indices on the memory-mapped access port (4-bit index)
   localparam logic [3:0] COMP_A_UPPER_IDX = 4'h0;
   localparam logic [3:0] COMP_A_LOWER_IDX = 4'h1;
   localparam logic [3:0] COMP_B_UPPER_IDX = 4'h2;
   localparam logic [3:0] COMP_B_LOWER_IDX = 4'h3;
   localparam logic [3:0] FIFO_UPPER_IDX = 4'h4;
   localparam logic [3:0] FIFO_LOWER_IDX = 4'h5;
   localparam logic [3:0] TRACE_CONTROL_IDX = 4'h6;
   localparam logic [3:0] FORCED_RESET_IDX = 4'h8;

   // trace control field positions
   localparam int TRACE_ENABLE_BIT = 7;
   localparam int CAPTURE_ARM_BIT = 6;
   localparam int CTRL_OTHER_W = 6;
   // forced-reset field position
   localparam int FORCE_RESET_BIT = 0;

   // values after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] FORCED_RESET_READ = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // capture storage
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 16;

   // one register access, from the cpu or from the background controller
   typedef struct packed {
      logic sel;         // access cycle
      logic wr;          // write strobe
      logic rd;          // read strobe
      logic fromDebug;   // access originated by a serial debug command
      logic [3:0] addr;  // register index
      logic [7:0] wdata; // write byte
   } dtra_acc_t;

   // one cpu bus cycle watched by the comparators
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] data;
   } dtra_bus_t;

   // one opcode fetch from the cpu
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } dtra_fetch_t;
endpackage : dtra_pkg

/* File: hdl/dtra_top.sv */
// debug trace register block: breakpoint, forced reset, comparators, capture fifo, control
`timescale 1ns/1ps
module dtra_top #(
   parameter int FIFO_DEPTH = dtra_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic resetn,
   // register access from cpu or background controller
   input wire dtra_pkg::dtra_acc_t regAcc,
   output logic [7:0] regRdata,
   // dedicated breakpoint commands from the background controller
   input wire logic writeBreakpointCmd,
   input wire logic [15:0] breakpointWdata,
   input wire logic readBreakpointCmd,
   output logic [15:0] breakpointRdata,
   // bits of the background status/control register
   input wire logic breakpointEnable,
   input wire logic forceOrTagSelect,
   // chip state
   input wire logic secureMode,
   input wire logic eventOnlyMode,
   input wire logic instrBoundary,
   // cpu activity
   input wire dtra_pkg::dtra_bus_t cpuBus,
   input wire dtra_pkg::dtra_fetch_t opcodeFetch,
   // results
   output logic mcuResetReq,
   output logic forceBackground,
   output logic tagOpcode,
   output logic captureArmed,
   output logic traceEnabled
);
   // one access port serves two masters; the source bit tells the background
   // controller apart from the running program, so the forced-reset register
   // can refuse program writes without a second bus
   // limitation: trigger modes are reduced to a begin trace on comparator a,
   // and the read/write qualifiers of the comparators are not modelled
   // trade-off: read data is registered, so every read answers one cycle
   // late, but the read mux never sits in the requesting bus's path
   // the breakpoint lives beside the trace registers but is never decoded
   // from the access port; only its dedicated commands reach it
   // all inputs come from logic on the system clock, so none is resynchronised
   // here; a pin-driven source would need two flip-flops in front

   // whole state of the block
   typedef struct packed {
      logic [15:0] bkpt;         // breakpoint match address
      logic [15:0] bkptRd;       // breakpoint read-back
      logic [15:0] compA;        // comparator a value
      logic [15:0] compB;        // comparator b value
      logic enable;              // trace module enable
      logic arm;                 // capture armed flag
      logic [5:0] ctrlOther;     // remaining control bits, kept as written
      logic triggered;           // begin trace has started storing
      logic [7:0] rdata;         // registered read data
      logic rstReq;              // full mcu reset request pulse
      logic forcePend;           // forced halt waiting for a boundary
      logic forceOut;            // forced halt pulse
      logic tagOut;              // tag pulse beside the fetch
      logic [15:0] lastFetch;    // most recently fetched opcode address
   } dtra_state_t;

   dtra_state_t st_r;
   dtra_state_t st_nxt;

   // fifo handshakes
   logic fifoClear;
   logic fifoPush;
   logic [15:0] fifoPushData;
   logic fifoShift;
   logic [15:0] fifoHead;
   logic fifoFull;

   // decoded access strobes
   logic wrCycle;
   logic rdCycle;
   logic cpuWrite;
   logic dbgWrite;
   logic compWriteOk;

   // capture and breakpoint match terms
   logic runActive;
   logic hitA;
   logic hitB;
   logic bkptHit;

   // access qualifiers
   always_comb begin
      wrCycle = regAcc.sel && regAcc.wr;
      rdCycle = regAcc.sel && regAcc.rd;
      // the source qualifier splits debug traffic from program traffic
      dbgWrite = wrCycle && regAcc.fromDebug;
      cpuWrite = wrCycle && !regAcc.fromDebug;
      // comparators freeze while a run is armed
      compWriteOk = wrCycle && !st_r.arm;
   end

   // comparator and breakpoint matches
   always_comb begin
      runActive = st_r.arm && st_r.enable;
      hitA = cpuBus.valid && (cpuBus.addr == st_r.compA);
      hitB = cpuBus.valid && (cpuBus.addr == st_r.compB);
      // addresses compare in full; the data byte is stored, never matched
      // a clear breakpoint enable ignores both the address and the mode bit
      bkptHit = breakpointEnable && opcodeFetch.valid
         && (opcodeFetch.addr == st_r.bkpt);
   end

   // capture feed into the fifo
   always_comb begin
      fifoClear = 1'b0;
      fifoPush = 1'b0;
      fifoPushData = dtra_pkg::WORD_RESET;
      // a fresh arm starts an empty run
      if (wrCycle && (regAcc.addr == dtra_pkg::TRACE_CONTROL_IDX)
         && regAcc.wdata[dtra_pkg::CAPTURE_ARM_BIT]) begin
         // only the count empties; old words are overwritten as the run refills
         fifoClear = 1'b1;
      end else if (runActive) begin
         if (eventOnlyMode) begin
            // only the low byte is kept; the upper half stays zero
            fifoPush = hitB;
            fifoPushData = {8'h00, cpuBus.data};
         end else begin
            // begin trace: store every matching address once triggered
            fifoPush = (st_r.triggered || hitA) && (hitA || hitB);
            fifoPushData = cpuBus.addr;
         end
      end
      // lower-byte reads advance only while nothing is armed
      // reading during a run skips no word but repeats the head
      fifoShift = rdCycle && (regAcc.addr == dtra_pkg::FIFO_LOWER_IDX)
         && !st_r.arm;
   end

   // capture storage; unarmed lower-byte reads load the last fetch into the tail
   dtra_fifo #(
      .WIDTH(dtra_pkg::FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clear(fifoClear),
      .push(fifoPush),
      .pushData(fifoPushData),
      .shift(fifoShift),
      .shiftData(st_r.lastFetch),
      .head(fifoHead),
      .full(fifoFull)
   );

   // next state of registers, strobes and capture control
   always_comb begin
      st_nxt = st_r;
      // strobes stand for one cycle only
      st_nxt.rstReq = 1'b0;
      st_nxt.forceOut = 1'b0;
      st_nxt.tagOut = 1'b0;

      // remember the latest opcode fetch for profiling
      // profiling reads store this address into the tail of the fifo
      if (opcodeFetch.valid) begin
         st_nxt.lastFetch = opcodeFetch.addr;
      end

      // breakpoint reached only through the dedicated commands
      if (writeBreakpointCmd) begin
         st_nxt.bkpt = breakpointWdata;
      end
      // a read beside a write returns the address held before the write
      if (readBreakpointCmd) begin
         st_nxt.bkptRd = st_r.bkpt;
      end

      // breakpoint action by the force/tag select
      // tag mode only marks the fetch; the core decides whether it executes
      if (bkptHit) begin
         if (forceOrTagSelect) begin
            st_nxt.forcePend = 1'b1;
         end else begin
            st_nxt.tagOut = 1'b1;
         end
      end
      // forced halt waits for the next instruction boundary
      // a match on a boundary cycle halts at once, with no pending cycle
      if ((st_r.forcePend || (bkptHit && forceOrTagSelect)) && instrBoundary) begin
         st_nxt.forcePend = 1'b0;
         st_nxt.forceOut = 1'b1;
      end
      if (!breakpointEnable) begin
         st_nxt.forcePend = 1'b0;
      end

      // begin-trace trigger on comparator a
      if (runActive && hitA && !eventOnlyMode) begin
         st_nxt.triggered = 1'b1;
      end
      // run completes when the fifo is full; auto-clear of arm
      // a run that never fills stays armed until software stops it
      if (runActive && fifoFull) begin
         st_nxt.arm = 1'b0;
         st_nxt.triggered = 1'b0;
      end

      // register writes
      if (wrCycle) begin
         case (regAcc.addr)
            dtra_pkg::COMP_A_UPPER_IDX: begin
               // a locked byte keeps its value while a run is armed
               if (compWriteOk) begin
                  st_nxt.compA[15:8] = regAcc.wdata;
               end
            end
            dtra_pkg::COMP_A_LOWER_IDX: begin
               if (compWriteOk) begin
                  st_nxt.compA[7:0] = regAcc.wdata;
               end
            end
            dtra_pkg::COMP_B_UPPER_IDX: begin
               // comparator b gates event-only stores as well as begin traces
               if (compWriteOk) begin
                  st_nxt.compB[15:8] = regAcc.wdata;
               end
            end
            dtra_pkg::COMP_B_LOWER_IDX: begin
               if (compWriteOk) begin
                  st_nxt.compB[7:0] = regAcc.wdata;
               end
            end
            dtra_pkg::TRACE_CONTROL_IDX: begin
               // control takes writes whether armed or not
               st_nxt.ctrlOther = regAcc.wdata[dtra_pkg::CTRL_OTHER_W-1:0];
               // enable can always be cleared, never set while secure
               st_nxt.enable = regAcc.wdata[dtra_pkg::TRACE_ENABLE_BIT]
                  && (st_r.enable || !secureMode);
               // software set beats a same-cycle completion clear; arming needs
               // the enable that this same write leaves behind
               st_nxt.arm = regAcc.wdata[dtra_pkg::CAPTURE_ARM_BIT]
                  && st_nxt.enable;
               // a zero in either bit stops the run at once
               if (!regAcc.wdata[dtra_pkg::CAPTURE_ARM_BIT]
                  || !regAcc.wdata[dtra_pkg::TRACE_ENABLE_BIT]) begin
                  st_nxt.arm = 1'b0;
               end
               st_nxt.triggered = 1'b0;
            end
            dtra_pkg::FORCED_RESET_IDX: begin
               if (cpuWrite) begin
                  // a program write falls on the floor, whatever its data
                  st_nxt.rstReq = 1'b0;
               end else if (dbgWrite && regAcc.wdata[dtra_pkg::FORCE_RESET_BIT]) begin
                  // only the host may pull the whole chip into reset
                  st_nxt.rstReq = 1'b1;
               end
            end
            // fifo bytes and unmapped indices ignore writes; the fifo is
            // loaded by captures and profiling reads only
            default: begin
               st_nxt.rstReq = 1'b0;
            end
         endcase
      end

      // register reads, answered one cycle later
      if (rdCycle) begin
         case (regAcc.addr)
            dtra_pkg::COMP_A_UPPER_IDX: begin
               // comparator bytes read back at all times, armed or not
               st_nxt.rdata = st_r.compA[15:8];
            end
            dtra_pkg::COMP_A_LOWER_IDX: begin
               st_nxt.rdata = st_r.compA[7:0];
            end
            dtra_pkg::COMP_B_UPPER_IDX: begin
               st_nxt.rdata = st_r.compB[15:8];
            end
            dtra_pkg::COMP_B_LOWER_IDX: begin
               st_nxt.rdata = st_r.compB[7:0];
            end
            dtra_pkg::FIFO_UPPER_IDX: begin
               // upper half is unused in event-only runs
               st_nxt.rdata = eventOnlyMode ? dtra_pkg::BYTE_RESET
                  : fifoHead[15:8];
            end
            dtra_pkg::FIFO_LOWER_IDX: begin
               // the head is taken before the shift on this same edge moves it
               st_nxt.rdata = fifoHead[7:0];
            end
            dtra_pkg::TRACE_CONTROL_IDX: begin
               st_nxt.rdata = {st_r.enable, st_r.arm, st_r.ctrlOther};
            end
            dtra_pkg::FORCED_RESET_IDX: begin
               st_nxt.rdata = dtra_pkg::FORCED_RESET_READ;
            end
            default: begin
               // holes in the index space read as zero rather than hold
               st_nxt.rdata = dtra_pkg::UNMAPPED_READ;
            end
         endcase
      end
   end

   // state register; everything clears on system reset
   // the fifo words clear in their own module on the same reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state
   // every output comes from a flip-flop, so no decode glitch reaches
   // the reset or halt requests of the chip
   assign regRdata = st_r.rdata;
   assign breakpointRdata = st_r.bkptRd;
   assign mcuResetReq = st_r.rstReq;
   assign forceBackground = st_r.forceOut;
   assign tagOpcode = st_r.tagOut;
   assign captureArmed = st_r.arm;
   assign traceEnabled = st_r.enable;
endmodule : dtra_top

/* File: verification/dtra_cpu_model.sv */
// cpu model: spins on one address, fetching and reading it every clock
`timescale 1ns/1ps
module dtra_cpu_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] pc,
   output dtra_pkg::dtra_fetch_t opcodeFetch,
   output dtra_pkg::dtra_bus_t cpuBus
);
   // a tight loop keeps the last fetched address known to the bench
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         opcodeFetch <= '0;
         cpuBus <= '0;
      end else begin
         opcodeFetch <= {1'b1, pc};
         cpuBus <= {1'b1, 1'b0, pc, pc[7:0]};
      end
   end
endmodule : dtra_cpu_model

/* File: verification/dtra_top_sva.sv */
// port-level assertions for the debug trace register block
`timescale 1ns/1ps
module dtra_top_sva #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire dtra_pkg::dtra_acc_t regAcc,
   input wire logic [7:0] regRdata,
   input wire logic writeBreakpointCmd,
   input wire logic [15:0] breakpointWdata,
   input wire logic readBreakpointCmd,
   input wire logic [15:0] breakpointRdata,
   input wire logic breakpointEnable,
   input wire logic forceOrTagSelect,
   input wire logic secureMode,
   input wire dtra_pkg::dtra_fetch_t opcodeFetch,
   input wire logic mcuResetReq,
   input wire logic tagOpcode,
   input wire logic captureArmed,
   input wire logic traceEnabled
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic rdAcc; // read cycle
   logic wrAcc; // write cycle
   logic [15:0] bpShadow_r; // last breakpoint written by the host
   assign rdAcc = regAcc.sel && regAcc.rd;
   assign wrAcc = regAcc.sel && regAcc.wr;
   // shadow copy of the breakpoint, cleared with the block
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) bpShadow_r <= 16'h0000;
      else if (writeBreakpointCmd) bpShadow_r <= breakpointWdata;
   end
   rst_pulse_a: assert property (
      wrAcc && regAcc.fromDebug && regAcc.addr == 4'h8 && regAcc.wdata[0] |=> mcuResetReq)
      else $error("forced reset not requested");
   cpu_rst_block_a: assert property (
      wrAcc && !regAcc.fromDebug && regAcc.addr == 4'h8 |=> !mcuResetReq)
      else $error("program write caused reset");
   rst_read_zero_a: assert property (
      rdAcc && regAcc.addr == 4'h8 |=> regRdata == 8'h00)
      else $error("forced reset read not zero");
   bp_read_a: assert property (
      readBreakpointCmd && !writeBreakpointCmd |=> breakpointRdata == bpShadow_r)
      else $error("breakpoint readback wrong");
   tag_hit_a: assert property (
      opcodeFetch.valid && breakpointEnable && !forceOrTagSelect && !writeBreakpointCmd
      && opcodeFetch.addr == bpShadow_r |=> tagOpcode)
      else $error("matching fetch not tagged");
   bp_off_a: assert property (
      !breakpointEnable |=> !tagOpcode)
      else $error("tag while breakpoint disabled");
   secure_hold_a: assert property (
      secureMode && !traceEnabled |=> !traceEnabled)
      else $error("enable set while secure");
   ctrl_stop_a: assert property (
      wrAcc && regAcc.addr == 4'h6 && !(regAcc.wdata[6] && regAcc.wdata[7]) |=> !captureArmed)
      else $error("capture not stopped");
   upper_hold_a: assert property (
      rdAcc && regAcc.addr == 4'h4 && !captureArmed ##1 !regAcc.sel ##1 rdAcc
      && regAcc.addr == 4'h4 |=> regRdata == $past(regRdata, 2))
      else $error("upper read moved fifo");
   arm_needs_en_a: assert property (
      captureArmed |-> traceEnabled)
      else $error("armed while trace disabled");
endmodule : dtra_top_sva
bind dtra_top dtra_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_dtra_top_sva (.*);

/* File: verification/dtra_top_tb.sv */
// self-checking bench for the debug trace register block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module dtra_top_tb;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   dtra_pkg::dtra_acc_t acc = '0; // register access
   logic [7:0] rdata;
   logic wbp = 1'b0, rbp = 1'b0;
   logic [15:0] bpW = 16'h0000, bpR, pc = 16'h0000;
   logic bpEn = 1'b0, force_or_tag_select = 1'b0, secure = 1'b0, evOnly = 1'b0, boundary = 1'b0;
   logic mcuRst, forceBg, tagOp, armed, enabled;
   dtra_pkg::dtra_fetch_t fetch;
   dtra_pkg::dtra_bus_t bus;
   int n_fail = 0, checked = 0, cyc = 0, rstSeen = 0, fbSeen = 0;
   always #2.5 sys_clk = ~sys_clk;
   dtra_top #(.FIFO_DEPTH(8)) i_dtra_top (.sys_clk(sys_clk), .resetn(resetn),
      .regAcc(acc), .regRdata(rdata), .writeBreakpointCmd(wbp), .breakpointWdata(bpW),
      .readBreakpointCmd(rbp), .breakpointRdata(bpR), .breakpointEnable(bpEn),
      .forceOrTagSelect(force_or_tag_select), .secureMode(secure), .eventOnlyMode(evOnly),
      .instrBoundary(boundary), .cpuBus(bus), .opcodeFetch(fetch), .mcuResetReq(mcuRst),
      .forceBackground(forceBg), .tagOpcode(tagOp), .captureArmed(armed),
      .traceEnabled(enabled));
   dtra_cpu_model i_dtra_cpu_model (.sys_clk(sys_clk), .resetn(resetn), .pc(pc),
      .opcodeFetch(fetch), .cpuBus(bus));
   // pulse counters and hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (mcuRst === 1'b1) rstSeen++;
      if (forceBg === 1'b1) fbSeen++;
      if (cyc == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task report_and_stop;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // one access cycle, then an idle cycle so strobes never toggle twice
   task automatic acc_cyc(input logic w, input logic dbg, input logic [3:0] a,
                          input logic [7:0] d);
      @(negedge sys_clk);
      acc = {1'b1, w, !w, dbg, a, d};
      @(negedge sys_clk);
      acc = '0;
   endtask : acc_cyc
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      acc_cyc(1'b0, 1'b0, a, 8'h00);
      `CHK(rdata, e)
   endtask : rchk
   task automatic wait_idle;
      for (int n = 0; n < 40 && armed; n++) @(negedge sys_clk);
   endtask : wait_idle
   // comparator bytes: reset, readback, lock while armed
   task automatic t_regs;
      for (int i = 0; i < 4; i++) rchk(4'(i), 8'h00);
      for (int i = 0; i < 4; i++) acc_cyc(1'b1, 1'b0, 4'(i), 8'h10 + 8'(i));
      for (int i = 0; i < 4; i++) rchk(4'(i), 8'h10 + 8'(i));
      acc_cyc(1'b1, 1'b0, 4'h6, 8'hc0);
      acc_cyc(1'b1, 1'b0, 4'h0, 8'hee);
      rchk(4'h0, 8'h10);
      rchk(4'h6, 8'hc0);
      acc_cyc(1'b1, 1'b0, 4'h6, 8'h80);
      `CHK(armed, 1'b0)
      acc_cyc(1'b1, 1'b0, 4'h6, 8'h00);
   endtask : t_regs
   // forced reset: program write ignored, host write resets, reads zero
   task automatic t_rst;
      acc_cyc(1'b1, 1'b0, 4'h8, 8'h01);
      `CHK(mcuRst, 1'b0)
      acc_cyc(1'b1, 1'b1, 4'h8, 8'h01);
      `CHK(mcuRst, 1'b1)
      rchk(4'h8, 8'h00);
      `CHK(rstSeen, 1)
   endtask : t_rst
   // breakpoint commands, tag, force and disable
   task automatic t_bp;
      @(negedge sys_clk);
      wbp = 1'b1;
      bpW = 16'h2468;
      @(negedge sys_clk);
      wbp = 1'b0;
      rbp = 1'b1;
      @(negedge sys_clk);
      rbp = 1'b0;
      `CHK(bpR, 16'h2468)
      pc = 16'h2468;
      bpEn = 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK(tagOp, 1'b1)
      force_or_tag_select = 1'b1;
      boundary = 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK(fbSeen != 0, 1'b1)
      force_or_tag_select = 1'b0;
      boundary = 1'b0;
      bpEn = 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(tagOp, 1'b0)
   endtask : t_bp
   // profiling: eight priming reads, ninth returns the first address
   task automatic t_prof;
      for (int k = 0; k < 8; k++) begin
         pc = 16'h3a5c + 16'(k);
         repeat (2) @(negedge sys_clk);
         acc_cyc(1'b0, 1'b0, 4'h5, 8'h00);
      end
      acc_cyc(1'b1, 1'b0, 4'h4, 8'hff);
      acc_cyc(1'b1, 1'b0, 4'h5, 8'hff);
      rchk(4'h4, 8'h3a);
      rchk(4'h4, 8'h3a);
      rchk(4'h5, 8'h5c);
      rchk(4'h5, 8'h5d);
   endtask : t_prof
   // armed capture runs to completion, full and event-only
   task automatic t_cap;
      pc = 16'h1011;
      acc_cyc(1'b1, 1'b0, 4'h6, 8'hc0);
      wait_idle();
      `CHK(armed, 1'b0)
      rchk(4'h4, 8'h10);
      rchk(4'h5, 8'h11);
      evOnly = 1'b1;
      pc = 16'h1213;
      acc_cyc(1'b1, 1'b0, 4'h6, 8'hc0);
      wait_idle();
      rchk(4'h4, 8'h00);
      rchk(4'h5, 8'h13);
      evOnly = 1'b0;
   endtask : t_cap
   // secure refusal and stop by clearing enable
   task automatic t_ctrl;
      pc = 16'h0000;
      acc_cyc(1'b1, 1'b0, 4'h6, 8'h00);
      secure = 1'b1;
      acc_cyc(1'b1, 1'b0, 4'h6, 8'hc0);
      `CHK(enabled, 1'b0)
      `CHK(armed, 1'b0)
      secure = 1'b0;
      acc_cyc(1'b1, 1'b0, 4'h6, 8'hc0);
      `CHK(armed, 1'b1)
      // lower reads while armed must leave the head in place
      for (int i = 0; i < 7; i++) acc_cyc(1'b0, 1'b0, 4'h5, 8'h00);
      rchk(4'h4, 8'h00);
      acc_cyc(1'b1, 1'b0, 4'h6, 8'h40);
      `CHK(armed, 1'b0)
   endtask : t_ctrl
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      t_regs();
      t_rst();
      t_bp();
      t_prof();
      t_cap();
      t_ctrl();
      report_and_stop();
   end
endmodule : dtra_top_tb
